// ### sim/dsc_dev.sv
`timescale 1ns/1ps
module dsc_dev (
  input wire logic              i_clk,
  input wire dsc_pkg::dsc_cmd_s i_cmd,
  input wire logic [15:0]       i_dq,
  input wire logic              i_dqs,
  input wire logic              i_dq_oe
);
  import dsc_pkg::*;
  logic [12:0] mode_r;
  logic [12:0] ext_r;
  logic [3:0]  open_r = 4'h0;
  logic [15:0] rcnt = 16'h0;
  logic [15:0] last;
  logic [7:0]  nbeat = 8'h0;
  logic        self_r = 1'b0;
  logic [3:0]  c;
  logic [11:0] wcol = 12'h0;
  logic [7:0]  wbase = 8'h0;
  logic [11:0] last_col;
  logic        dll_rst = 1'b0;
  assign c = {i_cmd.cs_n, i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
  function automatic logic [11:0] beat_col(input logic [11:0] s, input logic [2:0] k);
    logic [2:0] m;
    m = (mode_r[2:0] == 3'h1) ? 3'h1 : (mode_r[2:0] == 3'h2) ? 3'h3 : 3'h7;
    if (mode_r[3]) begin
      beat_col = s ^ {9'h0, k & m};
    end else begin
      beat_col = (s & ~{9'h0, m}) | {9'h0, (s[2:0] + k) & m};
    end
  endfunction : beat_col
  // Mode registers stay unknown until written, so a missed setup shows up
  always @(posedge i_clk) begin
    self_r <= !i_cmd.cke && (self_r || c == 4'h1);
    if (i_cmd.cke) begin
      case (c)
        4'h3: open_r[i_cmd.bank] <= 1'b1;
        4'h4: begin
          wcol  <= {i_cmd.addr[11], i_cmd.addr[9:0]};
          wbase <= nbeat;
          if (i_cmd.addr[10]) open_r[i_cmd.bank] <= 1'b0;
        end
        // Precharge only clears open flags (all of them with A10); a burst in flight is still captured on the strobe
        4'h2: open_r <= i_cmd.addr[10] ? 4'h0 : open_r & ~(4'h1 << i_cmd.bank);
        4'h1: rcnt <= rcnt + 16'h1;
        4'h0: if (!i_cmd.bank[1]) begin
          if (i_cmd.bank[0]) ext_r <= i_cmd.addr;
          else begin
            mode_r  <= i_cmd.addr;
            dll_rst <= i_cmd.addr[8];
          end
        end
        default: ;
      endcase
    end
  end
  always @(posedge i_dqs or negedge i_dqs) begin
    if (i_dq_oe) begin
      last <= i_dq;
      last_col <= beat_col(wcol, 3'(nbeat - wbase));
      nbeat <= nbeat + 8'h1;
    end
  end
endmodule : dsc_dev

// ### sim/dsc_host_asserts.sv
`timescale 1ns/1ps
module dsc_host_asserts #(parameter int REFI_CYC = 50) (
  input wire logic              i_clk,
  input wire logic              i_reset,
  input wire dsc_pkg::dsc_cmd_s o_cmd
);
  import dsc_pkg::*;
  logic [3:0]  c;
  logic        idle;
  logic        open_r;
  logic [15:0] ref_r;
  assign c = {o_cmd.cs_n, o_cmd.ras_n, o_cmd.cas_n, o_cmd.we_n};
  assign idle = c[3] || c == 4'h7;
  // One flag is enough: each request opens at most one bank
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      open_r <= 1'b0;
      ref_r  <= 16'h0;
    end else begin
      open_r <= c == 4'h3 || (open_r && c != 4'h2 && !(c == 4'h4 && o_cmd.addr[10]));
      ref_r  <= (c == 4'h1 || !o_cmd.cke) ? 16'h0 : ref_r + 16'h1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  chk_rcd_wait: assert property (c == 4'h3 |=> c != 4'h4)
    else $error("write too early");
  chk_no_stop: assert property (c == 4'h4 |=> (c != 4'h6) [*4])
    else $error("stop in write");
  // Slack covers a request in flight and the self refresh exit wait
  chk_refresh_due: assert property (ref_r <= REFI_CYC + 300)
    else $error("refresh late");
  chk_rfc_gap: assert property (c == 4'h1 && o_cmd.cke |=> idle [*7])
    else $error("command in refresh");
  chk_self_idle: assert property (c == 4'h1 && !o_cmd.cke |-> !open_r)
    else $error("self refresh with open bank");
  chk_wake_nop: assert property ($rose(o_cmd.cke) |-> idle)
    else $error("no nop on wake");
  chk_mode_idle: assert property (c == 4'h0 |-> !open_r && !o_cmd.bank[1])
    else $error("bad mode set");
  chk_rsv_bits: assert property (c == 4'h0 |-> (o_cmd.addr & 13'h1e80) == 13'h0)
    else $error("reserved bits set");
  cov_write: cover property (c == 4'h4);
  cov_self: cover property (c == 4'h1 && !o_cmd.cke);
  cov_mode: cover property (c == 4'h0);
endmodule : dsc_host_asserts
bind dsc_host dsc_host_asserts #(.REFI_CYC(REFI_CYC)) dsc_host_asserts_i (
  .i_clk(i_clk), .i_reset(i_reset), .o_cmd(o_cmd));

// ### sim/dsc_host_tb.sv
`timescale 1ns/1ps
module dsc_host_tb;
  import dsc_pkg::*;
  logic        i_clk = 1'b0, i_reset = 1'b1, i_link_clk = 1'b0;
  logic        i_req_valid = 1'b0, i_wake = 1'b0;
  logic [31:0] i_wdata = 32'h0;
  dsc_req_s    i_req = '0;
  dsc_cmd_s    o_cmd;
  logic [15:0] o_dq;
  logic        o_req_ready, o_done, o_bad_mode, o_dq_oe, o_dqs, o_dqs_oe, o_write_mask;
  int          bad_count = 0, checked = 0;
  always #5 i_clk = ~i_clk;
  initial begin
    #1.3;
    forever #3 i_link_clk = ~i_link_clk;
  end
  dsc_host #(.REFI_CYC(50), .RASMAX_CYC(40), .DW(16)) dsc_host_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_link_clk(i_link_clk), .i_req(i_req),
    .i_req_valid(i_req_valid), .i_wdata(i_wdata), .i_wake(i_wake),
    .o_req_ready(o_req_ready), .o_done(o_done), .o_bad_mode(o_bad_mode),
    .o_cmd(o_cmd), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_dqs(o_dqs),
    .o_dqs_oe(o_dqs_oe), .o_write_mask(o_write_mask));
  dsc_dev dsc_dev_i (.i_clk(i_clk), .i_cmd(o_cmd), .i_dq(o_dq), .i_dqs(o_dqs),
    .i_dq_oe(o_dq_oe));
  task automatic cyc(int k);
    repeat (k) @(negedge i_clk);
  endtask : cyc
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic req(dsc_op_e op, logic [12:0] v, logic x, logic ap, logic w);
    int n = 0;
    i_req = '{op: op, auto_pre: ap, value: v, ext: x, default: '0};
    i_req_valid = 1'b1;
    @(negedge i_clk);
    // Request stands until its answer is seen, so a refresh in between only delays it
    while (!(w ? o_done : !o_cmd.cke) && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    i_req_valid = 1'b0;
    chk("handshake", 32'(n < 2000), 32'h1);
  endtask : req
  task automatic t_mode;
    logic [12:0] v [7];
    logic        b;
    v = '{13'h0021, 13'h0022, 13'h0063, 13'h0020, 13'h0024, 13'h0033, 13'h1ba3};
    foreach (v[i]) begin
      req(DSC_OP_MODE, v[i], 1'b0, 1'b0, 1'b1);
      cyc(2);
      b = v[i][2:0] == 3'h0 || v[i][2] || (v[i][6:4] != 3'h2 && v[i][6:4] != 3'h6);
      chk("bad_mode", 32'(o_bad_mode), 32'(b));
      if (!b)
        chk("mode_reg", 32'(dsc_dev_i.mode_r), 32'(v[i] & 13'h017f));
    end
    req(DSC_OP_MODE, 13'h0003, 1'b1, 1'b0, 1'b1);
    cyc(2);
    chk("ext_reg", 32'(dsc_dev_i.ext_r), 32'h3);
    chk("mode_kept", 32'(dsc_dev_i.mode_r), 32'h123);
    chk("dll_reset", 32'(dsc_dev_i.dll_rst), 32'h1);
    $display("mode test done");
  endtask : t_mode
  task automatic t_write(logic ap);
    logic [7:0] b;
    b = dsc_dev_i.nbeat;
    i_wdata = 32'hbeef_1234;
    req(DSC_OP_WRITE, 13'h0, 1'b0, ap, 1'b1);
    cyc(4);
    chk("beats", 32'(dsc_dev_i.nbeat - b), 32'h8);
    chk("last_beat", 32'(dsc_dev_i.last), 32'hbeef);
    chk("last_col", 32'(dsc_dev_i.last_col), 32'h7);
    chk("open_banks", 32'(dsc_dev_i.open_r), 32'h0);
    $display("write test done");
  endtask : t_write
  task automatic t_sleep(dsc_op_e op);
    int n = 0;
    req(op, 13'h0, 1'b0, 1'b0, 1'b0);
    while (o_cmd.cke && n < 99) begin
      @(negedge i_clk);
      n++;
    end
    cyc(3);
    chk("cke", 32'(o_cmd.cke), 32'h0);
    chk("self", 32'(dsc_dev_i.self_r), 32'(op == DSC_OP_SELF));
    i_wake = 1'b1;
    n = 0;
    while (!(o_req_ready && o_cmd.cke) && n < 999) begin
      @(negedge i_clk);
      n++;
    end
    i_wake = 1'b0;
    chk("wake", 32'(n < 999), 32'h1);
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_refresh;
    logic [15:0] r;
    r = dsc_dev_i.rcnt;
    cyc(400);
    chk("refreshes", 32'((dsc_dev_i.rcnt - r) inside {[16'h6:16'h9]}), 32'h1);
    $display("refresh test done");
  endtask : t_refresh
  initial begin
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    i_reset = 1'b0;
    cyc(2);
    t_mode();
    t_write(1'b0);
    t_write(1'b1);
    t_sleep(DSC_OP_SELF);
    t_refresh();
    t_sleep(DSC_OP_PDOWN);
    t_refresh();
    end_sim();
  end
  // Roughly five times the expected run
  initial begin
    #60000;
    bad_count++;
    $display("Error watchdog expected done seen hang");
    end_sim();
  end
endmodule : dsc_host_tb

// ### verilog/dsc_cfg.svh
// Function
// RULE1: Write issues only after activate-to-column delay; data rides both strobe edges.
// RULE2: Write with auto precharge is never interrupted during its burst.
// RULE3: Every open bank is precharged within its maximum active time.
// RULE4: Precharge-all is legal with idle banks; only active banks close.
// RULE5: Precharge during read ends read data CAS latency cycles later.
// RULE6: Precharge during write resets the write input in that cycle.
// RULE7: After a write cut by precharge, mask stays high for write recovery.
// RULE8: Burst stop ends reads only; never sent during a write burst.
// RULE9: Refresh 8192 rows every 64 ms; the device counts rows.
// RULE10: Wait refresh cycle time after each auto refresh.
// RULE11: Self refresh is refresh encoding with clock enable low, all banks idle.
// RULE12: Distributed refresh every 7.8 us, also around self refresh.
// RULE13: Power down by clock enable low outside bursts; no-op after exit.
// RULE14: In power down the device disables buffers and its loop.
// RULE15: Mode registers written only with all banks idle, from address and bank pins.
// RULE16: Burst length code: 001 two, 010 four, 011 eight; others reserved.
// RULE17: Mode bit 3 selects sequential or interleave order.
// RULE18: Sequential order wraps inside the burst boundary.
// RULE19: CAS latency code 010 is 2, 110 is 2.5; others reserved.
// RULE20: Mode bit 8 set resets the delay-locked loop.
// RULE21: Bank select 00 regular, 01 extended, upper bit set reserved.
// RULE22: Extended bit 0 disables the loop, bit 1 selects half drive.
// RULE23: Test bit 7 and bits 9 to 12 are written as zero.
// RULE24: Register set is all four strobes low on a rising edge.
// RULE25: Burst stop is row and column strobes high, write enable low.
// RULE26: Interleave order XORs low start bits with the beat count.
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
`define DSC_CLK_NS         10
`define DSC_RCD_NS         20
`define DSC_RCD_CYC        ((`DSC_RCD_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_RAS_MAX_NS     70000
`define DSC_RAS_MAX_CYC    (`DSC_RAS_MAX_NS / `DSC_CLK_NS)
`define DSC_RFC_NS         80
`define DSC_RFC_CYC        ((`DSC_RFC_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_WR_NS          15
`define DSC_WR_CYC         ((`DSC_WR_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_REFI_PS        7800000
`define DSC_REFI_CYC       (`DSC_REFI_PS / (`DSC_CLK_NS * 1000))
`define DSC_XSR_CYC        200
`define DSC_BL_POS         0
`define DSC_ORDER_POS      3
`define DSC_CL_POS         4
`define DSC_DLLRST_POS     8
`define DSC_BL2            3'h1
`define DSC_BL4            3'h2
`define DSC_BL8            3'h3
`define DSC_CL2            3'h2
`define DSC_CL25           3'h6
`define DSC_XDLL_OFF_POS   0
`define DSC_XHALF_POS      1
`define DSC_BS_MODE        2'h0
`define DSC_BS_EXT         2'h1
`define DSC_A10_POS        10
`endif

// ### verilog/dsc_host.sv
`timescale 1ns/1ps
`include "dsc_cfg.svh"
module dsc_host #(
  parameter int REFI_CYC   = `DSC_REFI_CYC,
  parameter int RASMAX_CYC = `DSC_RAS_MAX_CYC,
  parameter int DW         = 16
) (
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_link_clk,
  input  wire dsc_pkg::dsc_req_s i_req,
  input  wire logic              i_req_valid,
  input  wire logic [2*DW-1:0]   i_wdata,
  input  wire logic              i_wake,
  output logic                   o_req_ready,
  output logic                   o_done,
  output logic                   o_bad_mode,
  output dsc_pkg::dsc_cmd_s      o_cmd,
  output logic [DW-1:0]          o_dq,
  output logic                   o_dq_oe,
  output logic                   o_dqs,
  output logic                   o_dqs_oe,
  output logic                   o_write_mask
);
  import dsc_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_ACT, S_RCD, S_WRITE, S_WBURST, S_PRE, S_RECOV, S_RFC,
    S_SELF, S_PDOWN, S_WAKE
  } dsc_st_e;

  localparam int CW = 17;

  typedef struct packed {
    dsc_st_e       st;
    dsc_req_s      req;
    dsc_cmd_s      cmd;
    logic [CW-1:0] cnt;
    logic [CW-1:0] refi;
    logic [CW-1:0] act_age;
    logic          open;
    logic [2:0]    bl;
    logic          ready;
    logic          done;
    logic          bad;
    logic          mask;
    logic          wtog;
    logic [2*DW-1:0] wdata;
    logic          refresh_due;
  } dsc_state_s;

  dsc_state_s s_r, s_nxt;

  // Link-domain write path: a toggle carries each burst start across
  logic [2:0] tog_sync_r;
  logic       tog_seen_r;
  logic [3:0] beats_r;
  logic       wr_act_r;
  logic [DW-1:0] dq_r;
  logic       dqs_r, dq_oe_r, dqs_oe_r;
  logic [2:0] wake_sync_r;

  function automatic dsc_cmd_s mk(input logic r, input logic c, input logic w,
                                  input logic [1:0] b, input logic [12:0] a,
                                  input logic ck);
    dsc_cmd_s x;
    x.cs_n  = 1'b0;
    x.ras_n = r;
    x.cas_n = c;
    x.we_n  = w;
    x.bank  = b;
    x.addr  = a;
    x.cke   = ck;
    return x;
  endfunction : mk

  function automatic logic [2:0] beats_of(input logic [2:0] code);
    unique case (code)
      `DSC_BL2: beats_of = 3'h1;
      `DSC_BL4: beats_of = 3'h2;
      default:  beats_of = 3'h4;
    endcase
  endfunction : beats_of

  localparam dsc_cmd_s NOP = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                               cke: 1'b1, bank: 2'h0, addr: 13'h0};

  always_comb begin
    logic [12:0] a;
    a = '0;
    s_nxt = s_r;
    s_nxt.cmd = NOP;
    s_nxt.done = 1'b0;
    s_nxt.ready = 1'b0;
    s_nxt.cnt = (s_r.cnt != '0) ? s_r.cnt - 1'b1 : s_r.cnt;
    if (s_r.st != S_SELF) begin
      s_nxt.refi = (s_r.refi != '0) ? s_r.refi - 1'b1 : s_r.refi;
    end
    if (s_r.refi == '0) begin
      s_nxt.refresh_due = 1'b1; // RULE9 RULE12
    end
    if (s_r.open) begin
      s_nxt.act_age = s_r.act_age + 1'b1;
    end
    unique case (s_r.st)
      S_IDLE: begin
        if (s_r.refresh_due) begin
          s_nxt.cmd = mk(1'b0, 1'b0, 1'b1, 2'h0, 13'h0, 1'b1); // RULE9
          s_nxt.refresh_due = 1'b0;
          s_nxt.refi = CW'(REFI_CYC);
          s_nxt.cnt = CW'(`DSC_RFC_CYC);
          s_nxt.st = S_RFC;
        end else if (i_req_valid) begin
          s_nxt.req = i_req;
          unique case (i_req.op)
            DSC_OP_WRITE, DSC_OP_READ: s_nxt.st = S_ACT;
            DSC_OP_MODE: begin
              // RULE15 RULE23: reserved and test bits forced to zero
              a = i_req.value & 13'h017f;
              if (!i_req.ext) begin
                s_nxt.bl = a[`DSC_BL_POS +: 3];
                s_nxt.bad = !((a[2:0] == `DSC_BL2) || (a[2:0] == `DSC_BL4) ||
                              (a[2:0] == `DSC_BL8)) ||
                            !((a[6:4] == `DSC_CL2) || (a[6:4] == `DSC_CL25)); // RULE16 RULE19
              end
              s_nxt.cmd = mk(1'b0, 1'b0, 1'b0, i_req.ext ? `DSC_BS_EXT : `DSC_BS_MODE,
                             a, 1'b1); // RULE21 RULE24
              s_nxt.done = 1'b1;
              s_nxt.cnt = CW'(2);
              s_nxt.st = S_RECOV;
            end
            DSC_OP_SELF: begin
              s_nxt.cmd = mk(1'b0, 1'b0, 1'b1, 2'h0, 13'h0, 1'b0); // RULE11
              s_nxt.st = S_SELF;
            end
            DSC_OP_PDOWN: begin
              s_nxt.cmd = NOP;
              s_nxt.cmd.cke = 1'b0; // RULE13
              s_nxt.st = S_PDOWN;
            end
            default: begin
              s_nxt.done = 1'b1;
              s_nxt.cnt = CW'(1);
              s_nxt.st = S_RECOV;
            end
          endcase
        end else begin
          s_nxt.ready = 1'b1;
        end
      end
      S_ACT: begin
        s_nxt.cmd = mk(1'b0, 1'b1, 1'b1, s_r.req.bank, s_r.req.row, 1'b1);
        s_nxt.open = 1'b1;
        s_nxt.act_age = '0;
        s_nxt.cnt = CW'(`DSC_RCD_CYC);
        s_nxt.st = S_RCD;
      end
      S_RCD: begin
        if (s_r.cnt <= CW'(1)) begin
          s_nxt.st = S_WRITE; // RULE1
        end
      end
      S_WRITE: begin
        a = {s_r.req.col[11], s_r.req.auto_pre, s_r.req.col[9:0]} & 13'h0fff;
        if (s_r.req.op == DSC_OP_WRITE) begin
          s_nxt.cmd = mk(1'b1, 1'b0, 1'b0, s_r.req.bank, a, 1'b1); // RULE1
          s_nxt.wtog = !s_r.wtog;
          s_nxt.wdata = i_wdata;
        end else begin
          s_nxt.cmd = mk(1'b1, 1'b0, 1'b1, s_r.req.bank, a, 1'b1);
        end
        s_nxt.cnt = CW'(beats_of(s_r.bl)) + CW'(2);
        s_nxt.st = S_WBURST;
      end
      S_WBURST: begin
        // RULE2 RULE8 RULE25: nothing issued until the whole burst has passed, except precharge of a burst without auto precharge near maximum active time
        if (s_r.cnt <= CW'(1) ||
            (s_r.act_age >= CW'(RASMAX_CYC - 4) && !s_r.req.auto_pre)) begin
          s_nxt.st = s_r.req.auto_pre ? S_RECOV : S_PRE;
          s_nxt.cnt = CW'(`DSC_WR_CYC);
          s_nxt.mask = (s_r.cnt > CW'(1)); // RULE7
          if (s_r.req.auto_pre) begin
            s_nxt.open = 1'b0;
          end
        end
      end
      S_PRE: begin
        // RULE3 RULE4: precharge-all closes whatever is open
        a = '0;
        a[`DSC_A10_POS] = 1'b1;
        s_nxt.cmd = mk(1'b0, 1'b1, 1'b0, 2'h0, a, 1'b1);
        s_nxt.open = 1'b0;
        s_nxt.cnt = CW'(`DSC_WR_CYC);
        s_nxt.st = S_RECOV;
      end
      S_RECOV: begin
        if (s_r.cnt <= CW'(1)) begin
          s_nxt.mask = 1'b0; // RULE7
          if (s_r.req.op == DSC_OP_WRITE || s_r.req.op == DSC_OP_READ) begin
            s_nxt.done = 1'b1;
          end
          s_nxt.req.op = DSC_OP_NONE;
          s_nxt.st = S_IDLE;
        end
      end
      S_RFC: begin
        if (s_r.cnt <= CW'(1)) begin
          s_nxt.st = S_IDLE; // RULE10
        end
      end
      S_SELF, S_PDOWN: begin
        s_nxt.cmd.cke = 1'b0; // RULE11 RULE13
        if (wake_sync_r[2] == wake_sync_r[1] && wake_sync_r[2]) begin
          s_nxt.cmd.cke = 1'b1;
          s_nxt.cnt = (s_r.st == S_SELF) ? CW'(`DSC_XSR_CYC) : CW'(1);
          s_nxt.refresh_due = (s_r.st == S_SELF); // RULE12
          s_nxt.st = S_WAKE;
        end
      end
      S_WAKE: begin
        if (s_r.cnt <= CW'(1)) begin
          s_nxt.done = 1'b1; // RULE13: no-op held while waking
          s_nxt.st = S_IDLE;
        end
      end
      default: begin
        s_nxt.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_r <= '{st: S_IDLE, req: '0, cmd: '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
               we_n: 1'b1, cke: 1'b0, bank: 2'h0, addr: 13'h0},
               cnt: '0, refi: '0, act_age: '0, open: 1'b0, bl: `DSC_BL2,
               ready: 1'b0, done: 1'b0, bad: 1'b0, mask: 1'b0, wtog: 1'b0,
               wdata: '0, refresh_due: 1'b0};
      wake_sync_r <= '0;
    end else begin
      s_r <= s_nxt;
      wake_sync_r <= {wake_sync_r[1:0], i_wake};
    end
  end

  // Link domain: data driven on the rising link edge, one word per link cycle
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      tog_sync_r <= '0;
      tog_seen_r <= 1'b0;
      beats_r    <= '0;
      wr_act_r   <= 1'b0;
      dq_r       <= '0;
      dq_oe_r    <= 1'b0;
      dqs_oe_r   <= 1'b0;
    end else begin
      tog_sync_r <= {tog_sync_r[1:0], s_r.wtog};
      if (tog_sync_r[2] == tog_sync_r[1] && tog_sync_r[2] != tog_seen_r) begin
        tog_seen_r <= tog_sync_r[2];
        beats_r    <= {beats_of(s_r.bl), 1'b0}; // RULE1
        wr_act_r   <= 1'b1;
        dq_oe_r    <= 1'b1;
        dqs_oe_r   <= 1'b1;
        dq_r       <= s_r.wdata[DW-1:0];
      end else if (wr_act_r) begin
        if (beats_r <= 4'h1) begin
          wr_act_r <= 1'b0;
          dq_oe_r  <= 1'b0;
          dqs_oe_r <= 1'b0;
        end else begin
          beats_r <= beats_r - 4'h1;
          dq_r    <= beats_r[0] ? s_r.wdata[DW-1:0] : s_r.wdata[2*DW-1:DW]; // RULE1
        end
      end
    end
  end

  // Strobe moves on the falling link edge so each edge sits mid-word
  always_ff @(negedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      dqs_r <= 1'b0;
    end else begin
      dqs_r <= wr_act_r ? !dqs_r : 1'b0; // RULE1
    end
  end

  always_comb begin
    o_req_ready  = s_r.ready;
    o_done       = s_r.done;
    o_bad_mode   = s_r.bad;
    o_cmd        = s_r.cmd;
    o_write_mask = s_r.mask;
    o_dq         = dq_r;
    o_dq_oe      = dq_oe_r;
    o_dqs        = dqs_r;
    o_dqs_oe     = dqs_oe_r;
  end
endmodule : dsc_host

// ### verilog/dsc_pkg.sv
package dsc_pkg;
  typedef enum logic [2:0] {
    DSC_OP_NONE, DSC_OP_WRITE, DSC_OP_READ, DSC_OP_REFRESH,
    DSC_OP_MODE, DSC_OP_SELF, DSC_OP_PDOWN, DSC_OP_STOP
  } dsc_op_e;
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic [1:0]  bank;
    logic [12:0] addr;
  } dsc_cmd_s;
  typedef struct packed {
    dsc_op_e     op;
    logic [1:0]  bank;
    logic [12:0] row;
    logic [11:0] col;
    logic        auto_pre;
    logic [12:0] value;
    logic        ext;
  } dsc_req_s;
endpackage : dsc_pkg
